/* inc/tsi_map.svh */
// register indices, field positions and reset values of the timer set
// assumes a 32-bit apb slave where byte address = 4 * register index
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH
// ******************************************
// register indices
// ******************************************
`define TSI_IDX_COUNT_CLOCK_CONTROL 6'h07
`define TSI_IDX_WATCHDOG_CONTROL 6'h08
`define TSI_IDX_COUNTERS_CLOCK_PRESCALE 6'h09
`define TSI_IDX_PULSE_TIMERS_CLOCK_PRESCALE 6'h0A
`define TSI_IDX_COUNTER_ONE_PRESET 6'h0B
`define TSI_IDX_COUNTER_TWO_PRESET 6'h0C
`define TSI_IDX_HIGH_PULSE_PRESET 6'h0D
`define TSI_IDX_LOW_PULSE_PRESET 6'h0E
`define TSI_IDX_INTERRUPT_MASK 6'h0F
`define TSI_IDX_INTERRUPT_STATUS 6'h10
`define TSI_IDX_INFRARED_CONTROL 6'h11
`define TSI_IDX_TIME_CLOCK_COUNTER 6'h12
// ******************************************
// field positions
// ******************************************
`define TSI_EXT_EDGE_BIT 7
`define TSI_GIE_BIT 6
`define TSI_SOURCE_BIT 5
`define TSI_EDGE_BIT 4
`define TSI_PRESCALER_ON_BIT 3
`define TSI_WATCHDOG_ON_BIT 3
`define TSI_IR_ON_BIT 0
`define TSI_MODULATE_BIT 1
`define TSI_LOW_ONLY_BIT 2
// ******************************************
// reset values
// ******************************************
`define TSI_RST_COUNT_CLOCK_CONTROL 8'hBF
`define TSI_RST_WATCHDOG_CONTROL 4'h7
`define TSI_RST_ZERO 8'h00
`endif

/* inc/tsi_pkg.sv */
// types shared by the timer set
// assumes nothing beyond the map header
package tsi_pkg;
    // phase of the generated pulse
    typedef enum logic [0:0] {
        TSI_PH_LOW = 1'b0,
        TSI_PH_HIGH = 1'b1
    } tsi_phase_e;
    // clock source and prescale code of one down-counter
    typedef struct packed {
        logic src;
        logic [2:0] rate;
    } tsi_tmr_cfg_s;
endpackage

/* core/tsi_timer_set.sv */
// timer set: two auto-reload counters, pulse width pair with infrared
// output, time clock counter, watchdog and interrupt mask, behind apb
// assumes oscillators, count pin and external interrupt pins are
// asynchronous and much slower than core_clk_i
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "tsi_map.svh"
module tsi_timer_set
    import tsi_pkg::*;
#(
    parameter int unsigned PSC_W = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // oscillators and pins
    input wire logic main_osc_clock_i,
    input wire logic sub_osc_clock_i,
    input wire logic instr_clock_i,
    input wire logic count_pin_i,
    input wire logic ext_irq_zero_i,
    input wire logic ext_irq_one_i,
    input wire logic port_change_i,
    // core instruction strobes
    input wire logic irq_disable_instr_i,
    input wire logic irq_enable_instr_i,
    input wire logic irq_return_instr_i,
    input wire logic irq_entry_i,
    // results
    output logic infrared_output_o,
    output logic irq_o,
    output logic watchdog_timeout_o
);
    localparam int unsigned NPIN = 7;

    if (PSC_W < 8) begin : g_bad_width
        $error("PSC_W below 8 cannot hold ratio 1:256");
    end

    // ******************************************
    // pin synchronisers
    // ******************************************
    logic [NPIN-1:0] pin_w;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_w, fall_w;
    assign pin_w = {port_change_i, ext_irq_one_i, ext_irq_zero_i, count_pin_i,
                    instr_clock_i, sub_osc_clock_i, main_osc_clock_i};
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        assign rise_w[i] = lvl_d[i] & ~lvl_q[i];
        assign fall_w[i] = ~lvl_d[i] & lvl_q[i];
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= pin_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // ******************************************
    // apb register file
    // ******************************************
    logic [7:0] tccr_q, tccr_d, cnt12_q, cnt12_d, pwcr_q, pwcr_d, imr_q, imr_d;
    logic [3:0] watchdog_control_q, watchdog_control_d;
    logic [2:0] irctl_q, irctl_d;
    logic [7:0] preset_q [4];
    logic [7:0] preset_d [4];
    logic [7:0] flags_q, tcc_q;
    logic gie_q;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [5:0] idx_w;
    logic wr_w, map_w;
    logic [7:0] rd_w, wd_w;
    assign idx_w = paddr_i[7:2];
    assign wd_w = pwdata_i[7:0];
    assign wr_w = psel_i & penable_i & pready_q & pwrite_i & map_w;

    always_comb begin
        map_w = 1'b1;
        rd_w = 8'h00;
        case (idx_w)
            `TSI_IDX_COUNT_CLOCK_CONTROL: begin
                rd_w = tccr_q;
                rd_w[`TSI_GIE_BIT] = gie_q;
            end
            `TSI_IDX_WATCHDOG_CONTROL: rd_w = {4'h0, watchdog_control_q};
            `TSI_IDX_COUNTERS_CLOCK_PRESCALE: rd_w = cnt12_q;
            `TSI_IDX_PULSE_TIMERS_CLOCK_PRESCALE: rd_w = pwcr_q;
            `TSI_IDX_COUNTER_ONE_PRESET: rd_w = preset_q[0];
            `TSI_IDX_COUNTER_TWO_PRESET: rd_w = preset_q[1];
            `TSI_IDX_HIGH_PULSE_PRESET: rd_w = preset_q[2];
            `TSI_IDX_LOW_PULSE_PRESET: rd_w = preset_q[3];
            `TSI_IDX_INTERRUPT_MASK: rd_w = imr_q;
            `TSI_IDX_INTERRUPT_STATUS: rd_w = flags_q;
            `TSI_IDX_INFRARED_CONTROL: rd_w = {5'h00, irctl_q};
            `TSI_IDX_TIME_CLOCK_COUNTER: rd_w = tcc_q;
            default: map_w = 1'b0;
        endcase
    end

    always_comb begin
        pready_d = psel_i & penable_i & ~pready_q;
        pslverr_d = psel_i & penable_i & ~pready_q & ~map_w;
        prdata_d = (psel_i & penable_i & ~pready_q) ? {24'h000000, rd_w} : prdata_q;
        tccr_d = tccr_q;
        watchdog_control_d = watchdog_control_q;
        cnt12_d = cnt12_q;
        pwcr_d = pwcr_q;
        imr_d = imr_q;
        irctl_d = irctl_q;
        preset_d = preset_q;
        if (wr_w) begin
            case (idx_w)
                `TSI_IDX_COUNT_CLOCK_CONTROL: tccr_d = wd_w;
                `TSI_IDX_WATCHDOG_CONTROL: watchdog_control_d = wd_w[3:0];
                `TSI_IDX_COUNTERS_CLOCK_PRESCALE: cnt12_d = wd_w;
                `TSI_IDX_PULSE_TIMERS_CLOCK_PRESCALE: pwcr_d = wd_w;
                `TSI_IDX_COUNTER_ONE_PRESET: preset_d[0] = wd_w;
                `TSI_IDX_COUNTER_TWO_PRESET: preset_d[1] = wd_w;
                `TSI_IDX_HIGH_PULSE_PRESET: preset_d[2] = wd_w;
                `TSI_IDX_LOW_PULSE_PRESET: preset_d[3] = wd_w;
                `TSI_IDX_INTERRUPT_MASK: imr_d = wd_w;
                `TSI_IDX_INFRARED_CONTROL: irctl_d = wd_w[2:0];
                default: irctl_d = irctl_q;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            tccr_q <= `TSI_RST_COUNT_CLOCK_CONTROL;
            watchdog_control_q <= `TSI_RST_WATCHDOG_CONTROL;
            cnt12_q <= `TSI_RST_ZERO;
            pwcr_q <= `TSI_RST_ZERO;
            imr_q <= `TSI_RST_ZERO;
            irctl_q <= 3'h0;
            for (int k = 0; k < 4; k++) begin
                preset_q[k] <= `TSI_RST_ZERO;
            end
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            tccr_q <= tccr_d;
            watchdog_control_q <= watchdog_control_d;
            cnt12_q <= cnt12_d;
            pwcr_q <= pwcr_d;
            imr_q <= imr_d;
            irctl_q <= irctl_d;
            preset_q <= preset_d;
        end
    end
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;

    // ******************************************
    // down-counters: 0 counter one, 1 counter two, 2 high, 3 low
    // ******************************************
    tsi_phase_e phase_q, phase_d;
    logic [15:0] cfg_w;
    logic [3:0] run_w, uflow_w, tick_w;
    logic [PSC_W-1:0] psc_q [4];
    logic [PSC_W-1:0] psc_d [4];
    logic [7:0] cnt_q [4];
    logic [7:0] cnt_d [4];
    logic ir_on_w, low_only_w, modulate_w;
    assign ir_on_w = irctl_q[`TSI_IR_ON_BIT];
    assign low_only_w = irctl_q[`TSI_LOW_ONLY_BIT];
    assign modulate_w = irctl_q[`TSI_MODULATE_BIT];
    assign cfg_w = {pwcr_q, cnt12_q};
    assign run_w[0] = 1'b1;
    assign run_w[1] = 1'b1;
    assign run_w[2] = ir_on_w & (phase_q == TSI_PH_HIGH) & ~low_only_w;
    assign run_w[3] = ir_on_w & ((phase_q == TSI_PH_LOW) | low_only_w);

    for (genvar k = 0; k < 4; k++) begin : g_tmr
        tsi_tmr_cfg_s cfg;
        logic edge_w;
        logic [PSC_W-1:0] lim_w;
        logic [8:0] ratio_w;
        assign cfg = tsi_tmr_cfg_s'(cfg_w[4*k+3:4*k]);
        assign edge_w = cfg.src ? rise_w[0] : rise_w[1];
        assign ratio_w = 9'h002 << cfg.rate;
        assign lim_w = PSC_W'(ratio_w - 9'h001);
        // >= so a lowered ratio does not send the prescaler round its full range
        assign tick_w[k] = run_w[k] & edge_w & (psc_q[k] >= lim_w);
        assign uflow_w[k] = tick_w[k] & (cnt_q[k] == 8'h00);
        always_comb begin
            psc_d[k] = psc_q[k];
            cnt_d[k] = cnt_q[k];
            if (!run_w[k]) begin
                psc_d[k] = '0;
                cnt_d[k] = preset_q[k];
            end else if (edge_w) begin
                psc_d[k] = (psc_q[k] >= lim_w) ? '0 : psc_q[k] + 1'b1;
                if (tick_w[k]) begin
                    cnt_d[k] = (cnt_q[k] == 8'h00) ? preset_q[k] : cnt_q[k] - 8'h01;
                end
            end
        end
        always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                psc_q[k] <= '0;
                cnt_q[k] <= 8'h00;
            end else begin
                psc_q[k] <= psc_d[k];
                cnt_q[k] <= cnt_d[k];
            end
        end
    end

    // ******************************************
    // infrared output
    // ******************************************
    logic carrier_q, carrier_d, ir_out_q, ir_out_d;
    always_comb begin
        carrier_d = carrier_q ^ uflow_w[1];
        phase_d = phase_q;
        if (!ir_on_w) begin
            phase_d = TSI_PH_HIGH;
        end else begin
            case (phase_q)
                TSI_PH_HIGH: if (uflow_w[2] | (low_only_w & uflow_w[3])) phase_d = TSI_PH_LOW;
                TSI_PH_LOW: if (uflow_w[3]) phase_d = TSI_PH_HIGH;
                default: phase_d = TSI_PH_HIGH;
            endcase
        end
        if (!ir_on_w) begin
            ir_out_d = 1'b0;
        end else if (phase_d == TSI_PH_HIGH) begin
            ir_out_d = 1'b1;
        end else begin
            ir_out_d = modulate_w & carrier_d;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_q <= 1'b0;
            phase_q <= TSI_PH_HIGH;
            ir_out_q <= 1'b0;
        end else begin
            carrier_q <= carrier_d;
            phase_q <= phase_d;
            ir_out_q <= ir_out_d;
        end
    end
    assign infrared_output_o = ir_out_q;

    // ******************************************
    // time clock counter and watchdog
    // ******************************************
    logic [7:0] tcc_d, tpsc_q, tpsc_d, tlim_w, wpsc_q, wpsc_d, wlim_w, wcnt_q, wcnt_d;
    logic tcc_edge_w, tcc_tick_w, tcc_ovf_w, wtick_w, wdt_to_q, wdt_to_d, tcc_wr_w;
    assign tcc_edge_w = tccr_q[`TSI_SOURCE_BIT] ?
                        (tccr_q[`TSI_EDGE_BIT] ? fall_w[3] : rise_w[3]) : rise_w[2];
    assign tlim_w = tccr_q[`TSI_PRESCALER_ON_BIT] ?
                    8'((9'h002 << tccr_q[2:0]) - 9'h001) : 8'h00;
    assign tcc_tick_w = tcc_edge_w & (tpsc_q >= tlim_w);
    assign tcc_ovf_w = tcc_tick_w & (tcc_q == 8'hFF);
    assign tcc_wr_w = wr_w & (idx_w == `TSI_IDX_TIME_CLOCK_COUNTER);
    assign wlim_w = 8'((9'h001 << watchdog_control_q[2:0]) - 9'h001);
    assign wtick_w = rise_w[1] & (wpsc_q == wlim_w);
    always_comb begin
        tcc_d = tcc_tick_w ? tcc_q + 8'h01 : tcc_q;
        tpsc_d = tcc_edge_w ? ((tpsc_q >= tlim_w) ? 8'h00 : tpsc_q + 8'h01) : tpsc_q;
        if (tcc_wr_w) begin
            tcc_d = wd_w;
            tpsc_d = 8'h00;
        end
        wpsc_d = rise_w[1] ? ((wpsc_q == wlim_w) ? 8'h00 : wpsc_q + 8'h01) : wpsc_q;
        wcnt_d = wtick_w ? wcnt_q + 8'h01 : wcnt_q;
        wdt_to_d = wtick_w & (wcnt_q == 8'hFF);
        if (!watchdog_control_q[`TSI_WATCHDOG_ON_BIT] || (wr_w && idx_w == `TSI_IDX_WATCHDOG_CONTROL)) begin
            wpsc_d = 8'h00;
            wcnt_d = 8'h00;
            wdt_to_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tcc_q <= 8'h00;
            tpsc_q <= 8'h00;
            wpsc_q <= 8'h00;
            wcnt_q <= 8'h00;
            wdt_to_q <= 1'b0;
        end else begin
            tcc_q <= tcc_d;
            tpsc_q <= tpsc_d;
            wpsc_q <= wpsc_d;
            wcnt_q <= wcnt_d;
            wdt_to_q <= wdt_to_d;
        end
    end
    assign watchdog_timeout_o = wdt_to_q;

    // ******************************************
    // status flags, global enable, request
    // ******************************************
    logic [7:0] flags_d, set_w, clr_w;
    logic gie_d, irq_q, irq_d, ext0_w;
    assign ext0_w = tccr_q[`TSI_EXT_EDGE_BIT] ? fall_w[4] : rise_w[4];
    assign set_w = {rise_w[6] | fall_w[6], uflow_w[3], uflow_w[2], uflow_w[1],
                    uflow_w[0], fall_w[5], ext0_w, tcc_ovf_w};
    assign clr_w = (wr_w && idx_w == `TSI_IDX_INTERRUPT_STATUS) ? wd_w : 8'h00;
    always_comb begin
        flags_d = (flags_q & ~clr_w) | set_w;
        gie_d = gie_q;
        if (irq_enable_instr_i | irq_return_instr_i) begin
            gie_d = 1'b1;
        end else if (irq_disable_instr_i | irq_entry_i) begin
            gie_d = 1'b0;
        end
        irq_d = (|(flags_q & imr_q)) & gie_q;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= 8'h00;
            gie_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            gie_q <= gie_d;
            irq_q <= irq_d;
        end
    end
    assign irq_o = irq_q;

    // ******************************************
    // assertions
    // ******************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_one_reload: assert property (uflow_w[0] |=> cnt_q[0] == $past(preset_q[0]))
        else $error("counter one did not reload preset");
    chk_two_reload: assert property (uflow_w[1] |=> cnt_q[1] == $past(preset_q[1]))
        else $error("counter two did not reload preset");
    chk_carrier_toggle: assert property (uflow_w[1] |=> carrier_q != $past(carrier_q))
        else $error("carrier missed a toggle");
    chk_high_end: assert property (uflow_w[2] && ir_on_w |=> phase_q == TSI_PH_LOW)
        else $error("high phase did not end on underflow");
    chk_low_reload: assert property (uflow_w[3] |=> cnt_q[3] == $past(preset_q[3]))
        else $error("low timer did not reload preset");
    chk_edge_flag: assert property (ext0_w |=> flags_q[1])
        else $error("external zero edge lost");
    chk_tcc_flag: assert property (tcc_ovf_w && !tcc_wr_w |=> flags_q[0] && tcc_q == 8'h00)
        else $error("count overflow not flagged");
    chk_gie_gate: assert property (!gie_q ##1 !gie_q |-> !irq_o)
        else $error("request raised with interrupts masked");
    chk_gie_disable: assert property (irq_disable_instr_i && !irq_enable_instr_i
        && !irq_return_instr_i |=> !gie_q)
        else $error("disable left global flag set");
    chk_wdt_off: assert property (!watchdog_control_q[`TSI_WATCHDOG_ON_BIT] |=> !watchdog_timeout_o)
        else $error("watchdog fired while off");
    chk_low_only: assert property (low_only_w ##1 low_only_w |->
        cnt_q[2] == preset_q[2] || $changed(preset_q[2]))
        else $error("high timer ran in low only shape");

    cov_one_uflow: cover property (uflow_w[0]);
    cov_ir_cycle: cover property (phase_q == TSI_PH_HIGH ##1 phase_q == TSI_PH_LOW);
    cov_irq_rise: cover property (!irq_o ##1 irq_o);
    cov_wdt_fire: cover property (watchdog_timeout_o);
endmodule

/* tb/tsi_far_side.sv */
// far-side model: oscillators, instruction clock and count pin
// assumes the bench calls pin_pulses from its main sequence
`timescale 1ns/1ps
module tsi_far_side (
    // oscillators
    output logic main_osc_clock_o,
    output logic sub_osc_clock_o,
    output logic instr_clock_o,
    // time clock counter pin
    output logic count_pin_o
);
    // odd start offsets keep oscillator edges off the core clock edges
    initial begin
        main_osc_clock_o = 1'b0;
        #13;
        forever #100 main_osc_clock_o = ~main_osc_clock_o;
    end
    initial begin
        sub_osc_clock_o = 1'b0;
        #7;
        forever #150 sub_osc_clock_o = ~sub_osc_clock_o;
    end
    initial begin
        instr_clock_o = 1'b0;
        #19;
        forever #200 instr_clock_o = ~instr_clock_o;
    end
    initial begin
        count_pin_o = 1'b0;
    end
    // pin period of 2 us stays well above the 400 ns instruction period
    task automatic pin_pulses(input int n);
        repeat (n) begin
            #1013 count_pin_o = 1'b1;
            #1000 count_pin_o = 1'b0;
        end
    endtask
endmodule

/* tb/timer_set_with_ir_pulse_control_test.sv */
// self-checking bench of the timer set
// assumes the far-side model drives the oscillators and the count pin
`timescale 1ns/1ps
`include "tsi_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module timer_set_with_ir_pulse_control_test;
    logic clk, rst_n, psel, penable, pwrite, ext0, ext1, port_chg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic pready, pslverr, err_q, ir, irq, wdt, main_osc, sub_osc, instr_clk, cnt_pin;
    logic [3:0] instr;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int wd_hits = 0;

    tsi_far_side i_tsi_far_side (.main_osc_clock_o(main_osc), .sub_osc_clock_o(sub_osc),
        .instr_clock_o(instr_clk), .count_pin_o(cnt_pin));
    tsi_timer_set #(.PSC_W(8)) i_tsi_timer_set (.core_clk_i(clk), .rst_n_i(rst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .main_osc_clock_i(main_osc), .sub_osc_clock_i(sub_osc), .instr_clock_i(instr_clk),
        .count_pin_i(cnt_pin), .ext_irq_zero_i(ext0), .ext_irq_one_i(ext1),
        .port_change_i(port_chg), .irq_disable_instr_i(instr[0]),
        .irq_enable_instr_i(instr[1]), .irq_return_instr_i(instr[2]),
        .irq_entry_i(instr[3]), .infrared_output_o(ir), .irq_o(irq),
        .watchdog_timeout_o(wdt));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdt === 1'b1) wd_hits <= wd_hits + 1;
    end

    // ******************************************
    // helpers
    // ******************************************
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic fail;
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        close_out();
    endtask
    function automatic logic near(input int a, input int b, input int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail();
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rd_q, {24'h0, e})
    endtask
    task automatic wr_rd(input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e);
        wr(idx, d);
        rd_chk(idx, e);
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        instr <= v;
        @(posedge clk);
        instr <= 4'h0;
    endtask
    task automatic wait_sig(input int which, input logic v);
        logic s;
        for (int n = 0; n < 5000; n++) begin
            @(posedge clk);
            s = (which == 0) ? ir : (which == 1) ? irq : wdt;
            if (s === v) return;
        end
        fail();
    endtask

    // ******************************************
    // scenarios
    // ******************************************
    task automatic t_irq;
        wr(`TSI_IDX_INTERRUPT_MASK, 8'h08);
        repeat (40) @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b0, `TSI_IDX_INTERRUPT_STATUS, 8'h00);
        `CHK(rd_q[3], 1'b1)
        pulse(4'b0010);
        rd_chk(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hFF);
        `CHK(irq, 1'b1)
        pulse(4'b0001);
        rd_chk(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hBF);
        `CHK(irq, 1'b0)
        pulse(4'b0100);
        wr(`TSI_IDX_INTERRUPT_MASK, 8'h00);
        rd_chk(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hFF);
        `CHK(irq, 1'b0)
        pulse(4'b1000);
        rd_chk(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hBF);
        pulse(4'b0010);
    endtask
    // measures the gap between two flag raises through the request line
    task automatic flag_period(input int b, input logic [5:0] idx, input logic [7:0] pre,
            input logic [7:0] cfg, input int e);
        int t0;
        wr(idx, pre);
        wr(`TSI_IDX_COUNTERS_CLOCK_PRESCALE, cfg);
        wr(`TSI_IDX_INTERRUPT_MASK, 8'h01 << b);
        wr(`TSI_IDX_INTERRUPT_STATUS, 8'hFF);
        wait_sig(1, 1'b0);
        wait_sig(1, 1'b1);
        t0 = cyc;
        wr(`TSI_IDX_INTERRUPT_STATUS, 8'hFF);
        wait_sig(1, 1'b0);
        wait_sig(1, 1'b1);
        `CHK(near(cyc - t0, e, 1), 1'b1)
    endtask
    task automatic ir_phases(input logic [7:0] ctl, input int eh, input int el);
        int t0;
        int th;
        wr(`TSI_IDX_INFRARED_CONTROL, ctl);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        t0 = cyc;
        wait_sig(0, 1'b0);
        th = cyc - t0;
        t0 = cyc;
        wait_sig(0, 1'b1);
        `CHK(near(th, eh, 1), 1'b1)
        `CHK(near(cyc - t0, el, 1), 1'b1)
    endtask
    task automatic t_carrier;
        int hi;
        int rises;
        logic prev;
        hi = 0;
        rises = 0;
        wr(`TSI_IDX_COUNTER_TWO_PRESET, 8'h00);
        wr(`TSI_IDX_COUNTERS_CLOCK_PRESCALE, 8'h88);
        wr(`TSI_IDX_INFRARED_CONTROL, 8'h03);
        repeat (160) @(posedge clk);
        prev = ir;
        for (int n = 0; n < 480; n++) begin
            @(posedge clk);
            hi += (ir === 1'b1);
            rises += (ir === 1'b1 && prev === 1'b0);
            prev = ir;
        end
        // half of each 24-cycle low phase carries a 16-cycle carrier
        `CHK(near(hi, 336, 4), 1'b1)
        // 3 or 4 rises per 80 cycles, by carrier alignment to the phases
        `CHK(near(rises, 21, 4), 1'b1)
    endtask
    task automatic ext_step(input logic v, input logic e);
        wr(`TSI_IDX_INTERRUPT_STATUS, 8'hFF);
        ext0 <= v;
        ext1 <= v;
        port_chg <= v;
        repeat (8) @(posedge clk);
        apb(1'b0, `TSI_IDX_INTERRUPT_STATUS, 8'h00);
        `CHK(rd_q[1], e)
        `CHK({rd_q[7], rd_q[2]}, {1'b1, ~v})
    endtask
    task automatic t_wdt;
        int t0;
        int h;
        wr(`TSI_IDX_WATCHDOG_CONTROL, 8'h08);
        t0 = cyc;
        wait_sig(2, 1'b1);
        `CHK(near(cyc - t0, 1536, 8), 1'b1)
        wr(`TSI_IDX_WATCHDOG_CONTROL, 8'h00);
        h = wd_hits;
        repeat (1700) @(posedge clk);
        `CHK(wd_hits, h)
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext0 = 1'b0;
        ext1 = 1'b0;
        port_chg = 1'b0;
        instr = 4'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hBF);
        rd_chk(`TSI_IDX_WATCHDOG_CONTROL, 8'h07);
        rd_chk(`TSI_IDX_INTERRUPT_MASK, 8'h00);
        t_irq();
        wr_rd(`TSI_IDX_COUNTER_ONE_PRESET, 8'hA5, 8'hA5);
        wr_rd(`TSI_IDX_COUNTER_TWO_PRESET, 8'h5A, 8'h5A);
        wr_rd(`TSI_IDX_HIGH_PULSE_PRESET, 8'h3C, 8'h3C);
        wr_rd(`TSI_IDX_LOW_PULSE_PRESET, 8'hC3, 8'hC3);
        wr_rd(`TSI_IDX_INTERRUPT_MASK, 8'h81, 8'h81);
        wr_rd(`TSI_IDX_WATCHDOG_CONTROL, 8'hF7, 8'h07);
        wr_rd(`TSI_IDX_COUNTERS_CLOCK_PRESCALE, 8'h88, 8'h88);
        wr_rd(`TSI_IDX_PULSE_TIMERS_CLOCK_PRESCALE, 8'h7F, 8'h7F);
        apb(1'b0, 6'h3F, 8'h00);
        `CHK({err_q, rd_q}, 33'h1_0000_0000)
        flag_period(3, `TSI_IDX_COUNTER_ONE_PRESET, 8'h03, 8'h08, 32);
        flag_period(4, `TSI_IDX_COUNTER_TWO_PRESET, 8'h01, 8'hA0, 64);
        flag_period(3, `TSI_IDX_COUNTER_ONE_PRESET, 8'h03, 8'h01, 96);
        wr(`TSI_IDX_PULSE_TIMERS_CLOCK_PRESCALE, 8'h88);
        wr(`TSI_IDX_HIGH_PULSE_PRESET, 8'h01);
        wr(`TSI_IDX_LOW_PULSE_PRESET, 8'h02);
        ir_phases(8'h01, 16, 24);
        ir_phases(8'h05, 24, 24);
        t_carrier();
        wr(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'h3F);
        ext_step(1'b1, 1'b1);
        ext_step(1'b0, 1'b0);
        wr(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hBF);
        ext_step(1'b1, 1'b0);
        ext_step(1'b0, 1'b1);
        wr(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hA0);
        wr(`TSI_IDX_TIME_CLOCK_COUNTER, 8'h00);
        i_tsi_far_side.pin_pulses(5);
        repeat (10) @(posedge clk);
        rd_chk(`TSI_IDX_TIME_CLOCK_COUNTER, 8'h05);
        wr(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'hB8);
        wr(`TSI_IDX_TIME_CLOCK_COUNTER, 8'h00);
        i_tsi_far_side.pin_pulses(4);
        repeat (10) @(posedge clk);
        rd_chk(`TSI_IDX_TIME_CLOCK_COUNTER, 8'h02);
        wr(`TSI_IDX_COUNT_CLOCK_CONTROL, 8'h80);
        wr(`TSI_IDX_TIME_CLOCK_COUNTER, 8'h00);
        repeat (80) @(posedge clk);
        apb(1'b0, `TSI_IDX_TIME_CLOCK_COUNTER, 8'h00);
        `CHK(near(int'(rd_q), 10, 1), 1'b1)
        t_wdt();
        close_out();
    end
endmodule
